// [hw/barrier_timebase_map.svh]
`ifndef BARRIER_TIMEBASE_MAP_SVH
`define BARRIER_TIMEBASE_MAP_SVH

// Counter select codes, as register numbers before the half swap
`define CNT_READ_LOW_CODE 10'h10c
`define CNT_READ_HIGH_CODE 10'h10d
`define CNT_WRITE_LOW_CODE 10'h11c
`define CNT_WRITE_HIGH_CODE 10'h11d

// Select field layout: the upper field slice carries the low five number bits
`define SEL_FIRST_MSB 9
`define SEL_FIRST_LSB 5
`define SEL_SECOND_MSB 4
`define SEL_SECOND_LSB 0

// Width of one counter half and the default core width
`define HALF_WIDTH 32
`define CORE_WIDTH 64

// Distance to the next sequential instruction
`define INSN_BYTES 64'h0000000000000004

`endif

// [hw/barrier_timebase_pkg.sv]
package barrier_timebase_pkg;

   typedef enum logic [2:0]
   {
      OP_READ_COUNTER = 3'h0,
      OP_WRITE_COUNTER = 3'h1,
      OP_FULL_SYNC = 3'h2,
      OP_IO_ORDER = 3'h3,
      OP_CTX_SYNC = 3'h4
   } insn_op_e;

   typedef enum logic [1:0]
   {
      ST_IDLE = 2'b00,
      ST_WAIT_PRIOR = 2'b01,
      ST_WAIT_MEM = 2'b10,
      ST_WAIT_ORDER = 2'b11
   } seq_state_e;

   typedef struct packed
   {
      logic valid;
      insn_op_e op;
      logic [9:0] selField;
      logic supervisor;
      logic [31:0] wrData;
      logic [63:0] pc;
   } insn_req_s;

   typedef struct packed
   {
      logic done;
      logic illegal;
      logic [63:0] data;
   } insn_resp_s;

   typedef struct packed
   {
      logic en;
      logic [63:0] value;
   } counter_wr_s;

   typedef struct packed
   {
      logic flush;
      logic [63:0] addr;
   } redirect_s;

   typedef struct packed
   {
      seq_state_e state;
      logic ready;
      logic isCtx;
      logic [63:0] pc;
      logic memReq;
      logic ordReq;
      insn_resp_s resp;
      counter_wr_s cwr;
      redirect_s redirect;
   } ctl_s;

endpackage

// [hw/select_code_match.sv]
`timescale 1ns/10ps
`include "barrier_timebase_map.svh"

module select_code_match
#(
   parameter logic [9:0] LOW_CODE = `CNT_READ_LOW_CODE,
   parameter logic [9:0] HIGH_CODE = `CNT_READ_HIGH_CODE
)
(
   input wire logic [9:0] selField,
   output logic hitLow,
   output logic hitHigh
);

   logic [9:0] regNumber;

   // Undo the half swap before comparing with the register number
   assign regNumber = {selField[`SEL_SECOND_MSB:`SEL_SECOND_LSB], selField[`SEL_FIRST_MSB:`SEL_FIRST_LSB]};
   assign hitLow = (regNumber == LOW_CODE);
   assign hitHigh = (regNumber == HIGH_CODE);

endmodule

// [hw/timebase_access_and_sync_barriers.sv]
`timescale 1ns/10ps
`include "barrier_timebase_map.svh"

// Operation
// [RULE1] User read accepts code 268 for low half, 269 for high half.
// [RULE2] Select field halves are swapped before matching the register number.
// [RULE3] Narrow core reads one 32-bit half per instruction into the destination.
// [RULE4] Wide core high-half read zero-fills destination upper 32 bits.
// [RULE5] Wide core low-half read returns the whole 64-bit counter.
// [RULE6] Supervisor writes use codes 284 and 285; these are write-only.
// [RULE7] Context barrier waits for earlier instructions, flushes prefetch, refetches next.
// [RULE8] Context barrier does not wait for memory accesses performed globally.
// [RULE9] Nothing after a barrier starts until the barrier completes.
// [RULE10] Later instructions refetch under context set by earlier instructions.
// [RULE11] Context barrier stays local; no signalling to other processors.
// [RULE12] I/O barrier orders earlier loads and stores before later ones.
// [RULE13] I/O barrier may take a variable number of cycles.
// [RULE14] Second-level cache should drain queued references on full barrier signalling.
// [RULE15] Full barrier completes after earlier instructions and global memory performance.
// [RULE16] Supervisor write replaces only the chosen half.
module timebase_access_and_sync_barriers
#(
   parameter int XLEN = `CORE_WIDTH
)
(
   input wire logic ref_clk,
   input wire logic resetn,
   input barrier_timebase_pkg::insn_req_s insnReq,
   output logic reqReady,
   output barrier_timebase_pkg::insn_resp_s resp,
   input wire logic [63:0] counterValue,
   output barrier_timebase_pkg::counter_wr_s counterWr,
   input wire logic priorDone,
   output logic memBarrierReq,
   input wire logic memBarrierAck,
   output logic orderReq,
   input wire logic orderAck,
   output barrier_timebase_pkg::redirect_s redirect
);
   import barrier_timebase_pkg::*;

   ctl_s st_q;
   ctl_s st_d;
   logic rdLow;
   logic rdHigh;
   logic wrLow;
   logic wrHigh;
   logic taken;

   // Only the two core widths have defined read behaviour
   generate
      if (XLEN != 32 && XLEN != 64)
      begin : g_bad_width
         $error("XLEN must be 32 or 64");
      end
   endgenerate

   // Read codes and write codes are matched separately so each stays one-way
   select_code_match #(.LOW_CODE(`CNT_READ_LOW_CODE), .HIGH_CODE(`CNT_READ_HIGH_CODE)) u_read_match
   (
      .selField(insnReq.selField),
      .hitLow(rdLow),
      .hitHigh(rdHigh)
   ); // [RULE1] [RULE2]

   select_code_match #(.LOW_CODE(`CNT_WRITE_LOW_CODE), .HIGH_CODE(`CNT_WRITE_HIGH_CODE)) u_write_match
   (
      .selField(insnReq.selField),
      .hitLow(wrLow),
      .hitHigh(wrHigh)
   ); // [RULE6]

   assign taken = insnReq.valid && st_q.ready;

   // Next-state logic; pulses fall back each cycle
   always_comb
   begin
      st_d = st_q;
      st_d.resp.done = 1'b0;
      st_d.resp.illegal = 1'b0;
      st_d.cwr.en = 1'b0;
      st_d.redirect.flush = 1'b0;
      unique case (st_q.state)
         ST_IDLE:
         begin
            if (taken)
            begin
               st_d.pc = insnReq.pc;
               st_d.isCtx = (insnReq.op == OP_CTX_SYNC);
               unique case (insnReq.op)
                  OP_READ_COUNTER:
                  begin
                     st_d.resp.done = 1'b1;
                     if (rdLow && XLEN == 64)
                     begin
                        st_d.resp.data = counterValue; // [RULE5]
                     end
                     else if (rdLow)
                     begin
                        st_d.resp.data = {32'h00000000, counterValue[31:0]}; // [RULE3]
                     end
                     else if (rdHigh)
                     begin
                        st_d.resp.data = {32'h00000000, counterValue[63:32]}; // [RULE3] [RULE4]
                     end
                     else
                     begin
                        // Write-only codes and unknown codes are refused
                        st_d.resp.data = 64'h0000000000000000;
                        st_d.resp.illegal = 1'b1; // [RULE6]
                     end
                  end
                  OP_WRITE_COUNTER:
                  begin
                     st_d.resp.done = 1'b1;
                     st_d.resp.data = 64'h0000000000000000;
                     if (insnReq.supervisor && wrLow)
                     begin
                        st_d.cwr.en = 1'b1;
                        st_d.cwr.value = {counterValue[63:32], insnReq.wrData}; // [RULE16]
                     end
                     else if (insnReq.supervisor && wrHigh)
                     begin
                        st_d.cwr.en = 1'b1;
                        st_d.cwr.value = {insnReq.wrData, counterValue[31:0]}; // [RULE16]
                     end
                     else
                     begin
                        st_d.resp.illegal = 1'b1; // [RULE6]
                     end
                  end
                  OP_IO_ORDER:
                  begin
                     // The memory side orders; no need to wait for retirement
                     st_d.state = ST_WAIT_ORDER;
                     st_d.ordReq = 1'b1; // [RULE12]
                     st_d.ready = 1'b0; // [RULE9]
                  end
                  OP_FULL_SYNC, OP_CTX_SYNC:
                  begin
                     st_d.state = ST_WAIT_PRIOR;
                     st_d.ready = 1'b0; // [RULE9]
                  end
                  default:
                  begin
                     st_d.resp.done = 1'b1;
                     st_d.resp.illegal = 1'b1;
                  end
               endcase
            end
         end
         ST_WAIT_PRIOR:
         begin
            if (priorDone && st_q.isCtx)
            begin
               // Local only: no memory or cache signalling for this barrier
               st_d.redirect.flush = 1'b1; // [RULE7] [RULE8] [RULE11]
               st_d.redirect.addr = st_q.pc + `INSN_BYTES; // [RULE10]
               st_d.resp.done = 1'b1;
               st_d.state = ST_IDLE;
               st_d.ready = 1'b1;
            end
            else if (priorDone)
            begin
               st_d.memReq = 1'b1; // [RULE14] [RULE15]
               st_d.state = ST_WAIT_MEM;
            end
         end
         ST_WAIT_MEM:
         begin
            // Ack means every earlier access is performed globally
            if (memBarrierAck)
            begin
               st_d.memReq = 1'b0;
               st_d.resp.done = 1'b1; // [RULE15]
               st_d.state = ST_IDLE;
               st_d.ready = 1'b1;
            end
         end
         ST_WAIT_ORDER:
         begin
            // Latency is set by the memory side, so no timeout here
            if (orderAck)
            begin
               st_d.ordReq = 1'b0;
               st_d.resp.done = 1'b1; // [RULE13]
               st_d.state = ST_IDLE;
               st_d.ready = 1'b1;
            end
         end
      endcase
   end

   // State register
   always_ff @(posedge ref_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         st_q <= '0;
         st_q.ready <= 1'b1;
      end
      else
      begin
         st_q <= st_d;
      end
   end

   // Outputs straight from the state register
   assign reqReady = st_q.ready;
   assign resp = st_q.resp;
   assign counterWr = st_q.cwr;
   assign memBarrierReq = st_q.memReq;
   assign orderReq = st_q.ordReq;
   assign redirect = st_q.redirect;

   sequence s_read_taken;
      taken && insnReq.op == OP_READ_COUNTER;
   endsequence

   sequence s_ctx_released;
      st_q.state == ST_WAIT_PRIOR && st_q.isCtx && priorDone;
   endsequence

   a_read_low_full: assert property (@(posedge ref_clk) disable iff (!resetn)
      s_read_taken and (rdLow && XLEN == 64) |=> resp.done && resp.data == $past(counterValue)) // [RULE5]
      else $error("low read did not return full counter");

   a_read_high_zero: assert property (@(posedge ref_clk) disable iff (!resetn)
      s_read_taken and rdHigh |=> resp.data == {32'h00000000, $past(counterValue[63:32])}) // [RULE4]
      else $error("high read not zero extended");

   a_read_code_swap: assert property (@(posedge ref_clk) disable iff (!resetn)
      s_read_taken and (insnReq.selField == 10'h188) |=> resp.done && !resp.illegal) // [RULE2]
      else $error("swapped low select code refused");

   a_write_only_codes: assert property (@(posedge ref_clk) disable iff (!resetn)
      s_read_taken and (wrLow || wrHigh) |=> resp.illegal) // [RULE6]
      else $error("write-only code was readable");

   a_write_half_keep: assert property (@(posedge ref_clk) disable iff (!resetn)
      taken && insnReq.op == OP_WRITE_COUNTER && insnReq.supervisor && wrHigh
      |=> counterWr.en && counterWr.value[31:0] == $past(counterValue[31:0])) // [RULE16]
      else $error("write touched other half");

   a_barrier_stall: assert property (@(posedge ref_clk) disable iff (!resetn)
      st_q.state != ST_IDLE |-> !reqReady) // [RULE9]
      else $error("request accepted during barrier");

   a_ctx_refetch: assert property (@(posedge ref_clk) disable iff (!resetn)
      s_ctx_released |=> redirect.flush && resp.done && redirect.addr == $past(st_q.pc) + `INSN_BYTES) // [RULE7]
      else $error("context barrier refetch wrong");

   a_ctx_local: assert property (@(posedge ref_clk) disable iff (!resetn)
      st_q.isCtx && st_q.state == ST_WAIT_PRIOR |-> !memBarrierReq && !orderReq) // [RULE11]
      else $error("context barrier signalled memory side");

   a_sync_no_early: assert property (@(posedge ref_clk) disable iff (!resetn)
      memBarrierReq && !memBarrierAck |=> !resp.done && memBarrierReq) // [RULE15]
      else $error("full barrier finished before ack");

   a_order_hold: assert property (@(posedge ref_clk) disable iff (!resetn)
      orderReq && !orderAck |=> orderReq && !resp.done ##0 $stable(st_q.state)) // [RULE13]
      else $error("order barrier dropped early");

endmodule

// [verif/mem_side_model.sv]
`timescale 1ns/10ps

module mem_side_model
(
   input wire logic ref_clk,
   input wire logic resetn,
   input wire logic [3:0] lat,
   input wire logic memBarrierReq,
   input wire logic orderReq,
   output logic memBarrierAck,
   output logic orderAck
);
   logic [3:0] waitCnt;

   // Acks are single pulses, so a stale ack never releases a later barrier
   always_ff @(posedge ref_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         waitCnt <= 4'h0;
         memBarrierAck <= 1'b0;
         orderAck <= 1'b0;
      end
      else if ((memBarrierReq || orderReq) && !memBarrierAck && !orderAck)
      begin
         waitCnt <= waitCnt + 4'h1;
         memBarrierAck <= memBarrierReq && (waitCnt == lat); // queue drained before ack
         orderAck <= orderReq && (waitCnt == lat); // latency set per test
      end
      else
      begin
         waitCnt <= 4'h0;
         memBarrierAck <= 1'b0;
         orderAck <= 1'b0;
      end
   end
endmodule

// [verif/timebase_access_and_sync_barriers_tb.sv]
`timescale 1ns/10ps

module timebase_access_and_sync_barriers_tb;
   import barrier_timebase_pkg::*;
   logic ref_clk;
   logic resetn;
   insn_req_s insnReq;
   logic reqReady;
   insn_resp_s resp;
   insn_resp_s resp32;
   logic [63:0] counterValue;
   counter_wr_s counterWr;
   logic priorDone;
   logic memBarrierReq;
   logic memBarrierAck;
   logic orderReq;
   logic orderAck;
   redirect_s redirect;
   logic [3:0] lat;
   logic [63:0] cv;
   int error_cnt;
   int samples_checked;

   // Wide core under test, narrow twin shares the inputs for half reads
   timebase_access_and_sync_barriers #(.XLEN(64)) dut (.ref_clk, .resetn, .insnReq, .reqReady, .resp,
      .counterValue, .counterWr, .priorDone, .memBarrierReq, .memBarrierAck, .orderReq, .orderAck, .redirect);
   timebase_access_and_sync_barriers #(.XLEN(32)) dut32 (.ref_clk, .resetn, .insnReq, .reqReady(),
      .resp(resp32), .counterValue, .counterWr(), .priorDone, .memBarrierReq(), .memBarrierAck,
      .orderReq(), .orderAck, .redirect());
   mem_side_model mem (.ref_clk, .resetn, .lat, .memBarrierReq, .memBarrierAck, .orderReq, .orderAck);

   // Free running clock
   initial
   begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end

   task chk(input logic [63:0] got, input logic [63:0] exp);
      samples_checked++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("BAD %0t got %h expected %h", $time, got, exp);
      end
   endtask

   task summarize;
      $display("checks %0d mismatches %0d", samples_checked, error_cnt);
      if (error_cnt == 0 && samples_checked > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   // One request, held one edge; the idle block always takes it there
   task issue(input insn_op_e op, input logic [9:0] sel, input logic sup);
      @(posedge ref_clk);
      insnReq <= '{1'b1, op, sel, sup, 32'h5a5a0f0f, 64'h1000};
      @(posedge ref_clk);
      insnReq.valid <= 1'b0;
   endtask

   task readChk(input logic [9:0] sel, input logic [63:0] e64, input logic [63:0] e32, input logic ill);
      issue(OP_READ_COUNTER, sel, 1'b0);
      // Done and illegal stand only in the cycle after the taking edge
      #1;
      chk(resp.done, 1'b1);
      chk(resp.illegal, ill);
      chk(resp.data, e64);
      chk(resp32.data, e32);
   endtask

   task writeChk(input logic [9:0] sel, input logic sup, input logic [63:0] ev, input logic en);
      issue(OP_WRITE_COUNTER, sel, sup);
      // Write enable is a one-cycle pulse, so look right after the taking edge
      #1;
      chk(resp.done, 1'b1);
      chk(resp.illegal, !en);
      chk(counterWr.en, en);
      if (en)
         chk(counterWr.value, ev);
   endtask

   // Barrier with earlier work still pending for four cycles after it is taken
   task barrier(input insn_op_e op, input logic [3:0] l);
      int n;
      logic sawMem;
      logic sawOrd;
      @(posedge ref_clk);
      lat <= l;
      priorDone <= 1'b0;
      issue(op, 10'h0, 1'b0);
      repeat (3)
      begin
         @(posedge ref_clk);
         #1;
         chk(reqReady, 1'b0);
         chk(resp.done, 1'b0);
         chk(memBarrierReq, 1'b0);
         chk(orderReq, op == OP_IO_ORDER);
      end
      @(posedge ref_clk);
      priorDone <= 1'b1;
      n = 0;
      sawMem = 1'b0;
      sawOrd = 1'b0;
      while (resp.done !== 1'b1 && n < 40)
      begin
         @(posedge ref_clk);
         #1;
         n++;
         sawMem |= memBarrierReq;
         sawOrd |= orderReq;
      end
      chk(resp.done, 1'b1);
      chk(reqReady, 1'b1);
      chk(sawMem, op == OP_FULL_SYNC);
      chk(sawOrd || op != OP_IO_ORDER, 1'b1);
      chk(redirect.flush, op == OP_CTX_SYNC);
      if (op == OP_CTX_SYNC)
         chk(redirect.addr, 64'h1004);
   endtask

   task testReads;
      readChk(10'h188, cv, {32'h0, cv[31:0]}, 1'b0);
      readChk(10'h1a8, {32'h0, cv[63:32]}, {32'h0, cv[63:32]}, 1'b0);
      readChk(10'h388, 64'h0, 64'h0, 1'b1);
      readChk(10'h10c, 64'h0, 64'h0, 1'b1);
      $display("reads finished");
   endtask

   task testWrites;
      writeChk(10'h388, 1'b1, {cv[63:32], 32'h5a5a0f0f}, 1'b1);
      writeChk(10'h3a8, 1'b1, {32'h5a5a0f0f, cv[31:0]}, 1'b1);
      writeChk(10'h388, 1'b0, 64'h0, 1'b0);
      writeChk(10'h188, 1'b1, 64'h0, 1'b0);
      issue(insn_op_e'(3'h5), 10'h0, 1'b1);
      #1;
      chk(resp.done, 1'b1);
      chk(resp.illegal, 1'b1);
      $display("writes finished");
   endtask

   task testBarriers;
      barrier(OP_CTX_SYNC, 4'h1);
      barrier(OP_FULL_SYNC, 4'h2);
      barrier(OP_FULL_SYNC, 4'h8);
      barrier(OP_IO_ORDER, 4'h5);
      barrier(OP_IO_ORDER, 4'h9);
      readChk(10'h188, cv, {32'h0, cv[31:0]}, 1'b0);
      $display("barriers finished");
   endtask

   // Hang guard, far above the fewer than a hundred cycles the tests need
   initial
   begin
      #50000;
      error_cnt++;
      summarize;
   end

   // Reset, then the scenarios in turn
   initial
   begin
      error_cnt = 0;
      samples_checked = 0;
      cv = 64'hfedcba9876543210;
      resetn = 1'b0;
      insnReq = '0;
      counterValue = cv;
      priorDone = 1'b1;
      lat = 4'h1;
      repeat (3) @(posedge ref_clk);
      resetn <= 1'b1;
      testReads;
      testWrites;
      testBarriers;
      summarize;
   end
endmodule
